//--- mbsp_pkg.sv
// Constants and register map for the bus strobe and power control block
// Behaviour
// - Reset held two machine cycles resets device
// - Latch strobe runs at oscillator over six
// - One latch pulse skipped per data access
// - Disable bit limits latch strobe to moves
// - Disable bit ignored during external execution
// - Fetch strobe twice per cycle, skip two
// - Select pin low fetches externally, high internal
// - Lock bit one latches select at reset
// - Select latch must match pin level
// - Oscillator divided by two before clocking
// - Idle halts processor, peripherals keep running
// - Interrupt or reset leaves idle mode
// - Idle strobes high, power-down strobes low
// - After idle reset, block RAM two cycles
// - Power-down stops oscillator after instruction
// - Only reset ends power-down, keeps RAM
// - Three lock bits select protection levels
// - Port zero multiplexes address and data
// - Programming takes port zero data, port one address
// - Latch strobe pin becomes program pulse input
// - Port three carries alternate functions
package mbsp_pkg;
    // ------------------------------------------------------------
    // Register map (word addresses on Avalon-MM)
    // ------------------------------------------------------------
    localparam logic [9:0] REG_STROBE_DIS = 10'h08E;
    localparam logic [9:0] REG_MODE_CTRL  = 10'h090;
    localparam logic [9:0] REG_STATUS     = 10'h091;
    localparam logic [9:0] REG_LOCK       = 10'h092;
    localparam int         BIT_ALE_DIS    = 0;
    localparam int         BIT_IDLE       = 0;
    localparam int         BIT_PDOWN      = 1;
    localparam int         BIT_XDATA      = 2;
    localparam int         BIT_MOVE       = 3;
    localparam logic [7:0] STROBE_DIS_RST = 8'h00;
    localparam logic [31:0] UNMAPPED_RD   = 32'h0000_0000;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         OSC_PER_MC     = 12;
    localparam int         STATES_PER_MC  = 6;
    localparam logic [2:0] LAST_STATE     = 3'h5;
    localparam logic [2:0] ALE_STATE_A    = 3'h0;
    localparam logic [2:0] ALE_STATE_B    = 3'h3;
    localparam logic [2:0] CODE_FETCH_STROBE_STATE_A   = 3'h1;
    localparam logic [2:0] CODE_FETCH_STROBE_STATE_B   = 3'h4;
    localparam int         RST_MIN_MC     = 2;
    localparam int         IDLE_RST_MC    = 2;
    localparam logic [3:0] RST_CNT_MAX    = 4'h2;
    typedef enum logic [1:0] {
        MBSP_RUN,
        MBSP_IDLE,
        MBSP_PDOWN
    } mbsp_mode_e;
endpackage : mbsp_pkg

//--- mbsp_ctrl.sv
// Bus strobe, fetch select and power mode control
module mbsp_ctrl
    import mbsp_pkg::*;
(
    input  wire logic        clk_i,            // Oscillator input (osc_amp_input)
    input  wire logic        sys_rst_i,        // Async reset, active high
    input  wire logic        rst_pin_i,        // Device reset pin level
    input  wire logic        external_fetch_select_i, // Fetch select strap
    input  wire logic        lock_bit_one_i,   // Lock bit 1 programmed
    input  wire logic        lock_bit_two_i,   // Lock bit 2 programmed
    input  wire logic        lock_bit_three_i, // Lock bit 3 programmed
    input  wire logic        program_pulse_in_mode_i,      // Flash programming active
    input  wire logic        irq_pending_i,    // Enabled interrupt pending
    input  wire logic        program_pulse_in_i, // Program pulse from pin
    input  wire logic [9:0]  avs_address,      // Word address
    input  wire logic        avs_read,         // Read request
    input  wire logic        avs_write,        // Write request
    input  wire logic [31:0] avs_writedata,    // Write data
    output logic      [31:0] avs_readdata,     // Read data
    output logic             avs_waitrequest,  // Stall
    output logic             ale_o,            // Address latch strobe level
    output logic             ale_oe_n_o,       // Latch pin drive, low drives
    output logic             code_fetch_strobe_n_o, // Fetch strobe, active low
    output logic             port_zero_float_o, // Port zero released
    output logic             port_two_addr_o,  // Port two drives address
    output logic             osc_run_o,        // Oscillator enable
    output logic             cpu_run_o,        // Processor clock enable
    output logic             ram_block_o,      // Internal RAM blocked
    output logic             dev_reset_o,      // Internal reset active
    output logic             ext_exec_o,       // External execution in use
    output logic             program_pulse_in_pulse_o      // Program pulse to flash
);
    // ------------------------------------------------------------
    // Clock divide and state counter
    // ------------------------------------------------------------
    logic       phase_r;
    logic [2:0] state_r;
    logic       mc_end;
    logic       dev_reset_r;
    mbsp_mode_e mode_r;
    logic       halt;

    // A pin reset restarts the divider so the reset can be qualified
    assign halt   = (mode_r == MBSP_PDOWN) && !rst_pin_i;
    assign mc_end = phase_r && (state_r == LAST_STATE);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_r <= 1'b0;
        end else if (!halt) begin
            phase_r <= ~phase_r;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= 3'h0;
        end else if (!halt && phase_r) begin
            state_r <= (state_r == LAST_STATE) ? 3'h0 : state_r + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Reset pin qualification
    // ------------------------------------------------------------
    // Counted in oscillator clocks so a pin high just before a cycle end
    // cannot pass as two full machine cycles
    localparam int RST_CLKS = RST_MIN_MC * OSC_PER_MC;
    logic [4:0] rst_cnt_r;
    logic       idle_rst_r;
    logic [3:0] idle_cnt_r;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rst_cnt_r <= 5'h00;
        end else if (!rst_pin_i) begin
            rst_cnt_r <= 5'h00;
        end else if (!halt && rst_cnt_r != 5'(RST_CLKS)) begin
            rst_cnt_r <= rst_cnt_r + 5'h01;
        end
    end

    // Pin reset in power-down wakes the divider so counting can proceed
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dev_reset_r <= 1'b1;
        end else begin
            dev_reset_r <= (rst_cnt_r == 5'(RST_CLKS)) && rst_pin_i;
        end
    end

    // Idle ended by reset: RAM blocked for two machine cycle ends, or until internal reset if that comes first
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            idle_rst_r <= 1'b0;
            idle_cnt_r <= 4'h0;
        end else if (dev_reset_r) begin
            idle_rst_r <= 1'b0;
            idle_cnt_r <= 4'h0;
        end else if (mode_r == MBSP_IDLE && rst_pin_i) begin
            idle_rst_r <= 1'b1;
        end else if (idle_rst_r && mc_end && idle_cnt_r != RST_CNT_MAX) begin
            idle_cnt_r <= idle_cnt_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] strobe_dis_r;
    logic       xdata_r;
    logic       move_r;
    logic       ea_latch_r;
    logic       wr_hit;
    logic       idle_req;
    logic       pd_req;

    assign wr_hit   = avs_write && !avs_waitrequest;
    assign idle_req = wr_hit && avs_address == REG_MODE_CTRL && avs_writedata[BIT_IDLE];
    assign pd_req   = wr_hit && avs_address == REG_MODE_CTRL && avs_writedata[BIT_PDOWN];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            strobe_dis_r <= STROBE_DIS_RST;
            xdata_r      <= 1'b0;
            move_r       <= 1'b0;
        end else if (dev_reset_r) begin
            strobe_dis_r <= STROBE_DIS_RST;
            xdata_r      <= 1'b0;
            move_r       <= 1'b0;
        end else if (wr_hit && avs_address == REG_STROBE_DIS) begin
            strobe_dis_r <= avs_writedata[7:0];
        end else if (wr_hit && avs_address == REG_MODE_CTRL) begin
            xdata_r <= avs_writedata[BIT_XDATA];
            move_r  <= avs_writedata[BIT_MOVE];
        end
    end

    // Strap caught by clocked logic while reset is held
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ea_latch_r <= 1'b1;
        end else if (dev_reset_r) begin
            ea_latch_r <= external_fetch_select_i;
        end
    end

    logic ext_exec;
    assign ext_exec = lock_bit_one_i ? !ea_latch_r : !external_fetch_select_i;

    // ------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_r <= MBSP_RUN;
        end else begin
            case (mode_r)
                MBSP_RUN: begin
                    if (pd_req) begin
                        mode_r <= MBSP_PDOWN;
                    end else if (idle_req) begin
                        mode_r <= MBSP_IDLE;
                    end
                end
                MBSP_IDLE: begin
                    if (irq_pending_i || dev_reset_r) begin
                        mode_r <= MBSP_RUN;
                    end
                end
                MBSP_PDOWN: begin
                    if (dev_reset_r) begin
                        mode_r <= MBSP_RUN;
                    end
                end
                default: mode_r <= MBSP_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Strobe generation
    // ------------------------------------------------------------
    logic ale_slot;
    logic code_fetch_strobe_slot;
    logic ale_skip;
    logic ale_gate;
    logic ale_nxt;
    logic code_fetch_strobe_nxt;
    logic drive_nxt;

    assign ale_slot  = !phase_r && (state_r == ALE_STATE_A || state_r == ALE_STATE_B);
    assign code_fetch_strobe_slot = !phase_r && (state_r == CODE_FETCH_STROBE_STATE_A || state_r == CODE_FETCH_STROBE_STATE_B);
    // Data access uses the second strobe slot of the cycle
    assign ale_skip  = xdata_r && state_r == ALE_STATE_B;
    assign ale_gate  = !strobe_dis_r[BIT_ALE_DIS] || ext_exec || move_r;

    always_comb begin
        ale_nxt   = ale_slot && !ale_skip && ale_gate;
        code_fetch_strobe_nxt  = !(ext_exec && code_fetch_strobe_slot && !xdata_r);
        drive_nxt = ale_gate;
        case (mode_r)
            MBSP_IDLE: begin
                ale_nxt   = 1'b1;
                code_fetch_strobe_nxt  = 1'b1;
                drive_nxt = 1'b1;
            end
            MBSP_PDOWN: begin
                ale_nxt   = 1'b0;
                code_fetch_strobe_nxt  = 1'b0;
                drive_nxt = 1'b1;
            end
            default: ;
        endcase
        if (program_pulse_in_mode_i) begin
            drive_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ale_o                 <= 1'b0;
            ale_oe_n_o            <= 1'b1;
            code_fetch_strobe_n_o <= 1'b1;
            port_zero_float_o     <= 1'b0;
            port_two_addr_o       <= 1'b0;
            osc_run_o             <= 1'b1;
            cpu_run_o             <= 1'b0;
            ram_block_o           <= 1'b0;
            dev_reset_o           <= 1'b1;
            ext_exec_o            <= 1'b0;
            program_pulse_in_pulse_o          <= 1'b0;
        end else begin
            ale_o                 <= ale_nxt;
            ale_oe_n_o            <= !drive_nxt; // Weak pull-up otherwise
            code_fetch_strobe_n_o <= code_fetch_strobe_nxt;
            port_zero_float_o     <= ext_exec && mode_r != MBSP_RUN;
            port_two_addr_o       <= ext_exec && mode_r == MBSP_IDLE;
            osc_run_o             <= !halt || rst_pin_i;
            cpu_run_o             <= mode_r == MBSP_RUN && !dev_reset_r;
            ram_block_o           <= idle_rst_r && idle_cnt_r != RST_CNT_MAX;
            dev_reset_o           <= dev_reset_r;
            ext_exec_o            <= ext_exec;
            program_pulse_in_pulse_o          <= program_pulse_in_mode_i && !program_pulse_in_i;
        end
    end

    // ------------------------------------------------------------
    // Avalon slave: one wait cycle then answer
    // ------------------------------------------------------------
    logic req_seen_r;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            req_seen_r <= 1'b0;
        end else begin
            req_seen_r <= (avs_read || avs_write) && !req_seen_r;
        end
    end

    always_comb begin
        avs_waitrequest = (avs_read || avs_write) && !req_seen_r;
        avs_readdata    = UNMAPPED_RD;
        if (avs_address == REG_STROBE_DIS) begin
            avs_readdata = {24'h0, strobe_dis_r};
        end else if (avs_address == REG_MODE_CTRL) begin
            avs_readdata = {28'h0, move_r, xdata_r, halt, mode_r == MBSP_IDLE};
        end else if (avs_address == REG_STATUS) begin
            avs_readdata = {28'h0, ram_block_o, dev_reset_r, ea_latch_r, ext_exec};
        end else if (avs_address == REG_LOCK) begin
            avs_readdata = {29'h0, lock_bit_three_i, lock_bit_two_i, lock_bit_one_i};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_idle_strobes_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r == MBSP_IDLE |=> ale_o && code_fetch_strobe_n_o)
        else $error("strobes not high in idle");
    a_pd_strobes_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r == MBSP_PDOWN |=> !ale_o && !code_fetch_strobe_n_o)
        else $error("strobes not low in power-down");
    a_ale_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(ale_o) && mode_r == MBSP_RUN && ale_gate && !xdata_r && !dev_reset_r
        |=> !ale_o [*5] ##1 (ale_o || mode_r != MBSP_RUN || xdata_r || !ale_gate))
        else $error("latch strobe period wrong");
    a_pd_exit_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r == MBSP_PDOWN && !dev_reset_r |=> mode_r != MBSP_RUN)
        else $error("power-down left without reset");
    a_reset_qualify: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !rst_pin_i |=> !dev_reset_r)
        else $error("reset without pin");
    a_no_fetch_internal: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !ext_exec && mode_r == MBSP_RUN |=> code_fetch_strobe_n_o)
        else $error("fetch strobe during internal run");
    a_ale_disabled: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r == MBSP_RUN && !program_pulse_in_mode_i && !ale_gate |=> ale_oe_n_o && !ale_o)
        else $error("latch strobe driven while disabled");
    a_xdata_skip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        xdata_r && state_r == ALE_STATE_B && mode_r == MBSP_RUN |=> !ale_o)
        else $error("latch pulse not skipped");
    a_program_pulse_in_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        program_pulse_in_mode_i |=> ale_oe_n_o)
        else $error("latch pin driven in programming");

    a_fetch_single: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !code_fetch_strobe_n_o && mode_r == MBSP_RUN && $past(mode_r) == MBSP_RUN
        |=> code_fetch_strobe_n_o)
        else $error("fetch strobe wider than one clock");

    a_reset_pin_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(dev_reset_r) |-> $past(rst_pin_i, 8) && rst_pin_i)
        else $error("internal reset after short pin pulse");

    a_pd_osc_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r == MBSP_PDOWN && !rst_pin_i |=> !osc_run_o)
        else $error("oscillator running in power-down");

    a_idle_port_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r == MBSP_IDLE && ext_exec |=> port_two_addr_o && port_zero_float_o)
        else $error("idle port states wrong");

    a_pd_port_states: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r == MBSP_PDOWN && ext_exec |=> !port_two_addr_o && port_zero_float_o)
        else $error("power-down port states wrong");

    a_idle_ale_drive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r == MBSP_IDLE && !program_pulse_in_mode_i |=> !ale_oe_n_o)
        else $error("latch pin not driven in idle");

    a_cpu_halted: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r != MBSP_RUN |=> !cpu_run_o)
        else $error("processor runs outside run mode");

    a_divider_frozen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        halt |=> $stable(phase_r))
        else $error("divider moves while oscillator stopped");

    a_divider_toggle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !halt |=> phase_r != $past(phase_r))
        else $error("divider did not toggle");

    a_program_pulse_in_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        program_pulse_in_mode_i && !program_pulse_in_i |=> program_pulse_in_pulse_o)
        else $error("program pulse not passed on");

    a_ram_block_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        dev_reset_r |=> ##1 !ram_block_o)
        else $error("RAM still blocked under internal reset");

    a_wait_bounded: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        avs_waitrequest |=> !avs_waitrequest)
        else $error("bus stalled more than one cycle");

    a_ea_latch_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !dev_reset_r |=> $stable(ea_latch_r))
        else $error("select latch changed outside reset");

    c_xdata_skip: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        xdata_r && state_r == ALE_STATE_B && mode_r == MBSP_RUN);
    c_pin_reset: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(dev_reset_r));
    c_idle_enter: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r == MBSP_RUN ##1 mode_r == MBSP_IDLE);
    c_pd_exit: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        mode_r == MBSP_PDOWN ##1 mode_r == MBSP_RUN);
    c_ram_block: cover property (@(posedge clk_i) disable iff (sys_rst_i) ram_block_o);
endmodule : mbsp_ctrl

//--- mbsp_mem_model.sv
// External memory and programmer model on the far side of the strobe pins
module mbsp_mem_model (
    input  wire logic clk_i,       // Clock
    input  wire logic clr_i,       // Clear both counters
    input  wire logic ale_i,       // Address latch strobe
    input  wire logic fetch_n_i,   // Code fetch strobe, active low
    input  wire logic program_pulse_in_req_i,  // Bench asks for a program pulse
    output logic      program_pulse_in_n_o,    // Program pulse line, active low
    output int        latch_cnt_o, // Latch strobes seen
    output int        fetch_cnt_o  // Fetch strobes seen
);
    // ------------------------------------------------------------
    // Strobe counters
    // ------------------------------------------------------------
    // A latch strobe marks the low address byte on the shared bus
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            latch_cnt_o <= 0;
            fetch_cnt_o <= 0;
        end else begin
            latch_cnt_o <= latch_cnt_o + int'(ale_i === 1'b1);
            fetch_cnt_o <= fetch_cnt_o + int'(fetch_n_i === 1'b0);
        end
    end
    // Line rests at its pull-up level between pulses
    assign program_pulse_in_n_o = program_pulse_in_req_i ? 1'b0 : 1'b1;
endmodule : mbsp_mem_model

//--- testbench.sv
// Self-checking bench for the bus strobe and power control block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import mbsp_pkg::*;
    typedef struct packed {logic [9:0] a; logic w; logic [31:0] d; logic [31:0] e;} mbsp_row_s;
    logic        clk_i, sys_rst_i, rst_pin_i, sel_i, lb1_i, program_pulse_in_mode_i, irq_i, clr, preq;
    logic        program_pulse_in_n, avs_read, avs_write, avs_waitrequest;
    logic [9:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, v;
    logic        ale_o, ale_oe_n_o, fetch_n_o, p0_float_o, p2_addr_o, osc_run_o, cpu_run_o;
    logic        ram_block_o, dev_reset_o, ext_exec_o, program_pulse_in_pulse_o, seen;
    int          err_total, checks_done, n_ale, n_fetch;
    mbsp_row_s   rows [7] = '{
        '{REG_STROBE_DIS, 1'b0, 32'h0, {24'h0, STROBE_DIS_RST}}, '{REG_STROBE_DIS, 1'b1, 32'h1, 32'h0},
        '{REG_STROBE_DIS, 1'b0, 32'h0, 32'h1}, '{REG_STROBE_DIS, 1'b1, 32'h0, 32'h0},
        '{10'h1FF, 1'b0, 32'h0, UNMAPPED_RD}, '{10'h1FF, 1'b1, 32'h5A, 32'h0},
        '{REG_LOCK, 1'b0, 32'h0, 32'h2}};
    mbsp_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rst_pin_i(rst_pin_i),
        .external_fetch_select_i(sel_i), .lock_bit_one_i(lb1_i), .lock_bit_two_i(1'b1),
        .lock_bit_three_i(1'b0), .program_pulse_in_mode_i(program_pulse_in_mode_i), .irq_pending_i(irq_i),
        .program_pulse_in_i(program_pulse_in_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ale_o(ale_o), .ale_oe_n_o(ale_oe_n_o),
        .code_fetch_strobe_n_o(fetch_n_o), .port_zero_float_o(p0_float_o),
        .port_two_addr_o(p2_addr_o), .osc_run_o(osc_run_o), .cpu_run_o(cpu_run_o),
        .ram_block_o(ram_block_o), .dev_reset_o(dev_reset_o), .ext_exec_o(ext_exec_o),
        .program_pulse_in_pulse_o(program_pulse_in_pulse_o));
    mbsp_mem_model mem (.clk_i(clk_i), .clr_i(clr), .ale_i(ale_o), .fetch_n_i(fetch_n_o),
        .program_pulse_in_req_i(preq), .program_pulse_in_n_o(program_pulse_in_n), .latch_cnt_o(n_ale), .fetch_cnt_o(n_fetch));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        checks_done++;
        if (seen_v !== exp_v) begin
            err_total++;
            $display("Error %0t: saw %h expected %h", $time, seen_v, exp_v);
        end
    endtask : chk
    task automatic complete_run();
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    // Request held until waitrequest is sampled low at an edge
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) chk(32'h1, 32'h0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus
    // Five machine cycles of strobes, counted by the memory model
    task automatic measure();
        cyc(12);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        cyc(60);
        @(negedge clk_i);
    endtask : measure
    task automatic pin_reset(input int n);
        rst_pin_i <= 1'b1;
        cyc(n);
        rst_pin_i <= 1'b0;
        for (int i = 0; i < 100 && (dev_reset_o !== 1'b0 || osc_run_o !== 1'b1); i++) cyc(1);
        cyc(2);
    endtask : pin_reset
    // ------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        cyc(20000);
        err_total++;
        complete_run();
    end
    initial begin
        {rst_pin_i, lb1_i, program_pulse_in_mode_i, irq_i, clr, preq, avs_read, avs_write} = '0;
        {sys_rst_i, sel_i} = 2'b11;
        avs_address = '0;
        avs_writedata = '0;
        err_total = 0;
        checks_done = 0;
        cyc(20);
        chk({dev_reset_o, cpu_run_o, ale_o}, 3'b100);
        sys_rst_i <= 1'b0;
        cyc(40);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d, v);
            if (!rows[i].w) chk(v, rows[i].e);
        end
        measure();
        chk(n_ale, 10);
        chk(n_fetch, 0);
        bus(1'b1, REG_STROBE_DIS, 32'h1, v);
        measure();
        chk({n_ale[30:0], ale_oe_n_o}, 32'h1);
        bus(1'b1, REG_MODE_CTRL, 32'h8, v);
        measure();
        chk(n_ale, 10);
        bus(1'b1, REG_MODE_CTRL, 32'h0, v);
        sel_i <= 1'b0;
        measure();
        chk(ext_exec_o, 1);
        chk(n_ale, 10);
        chk(n_fetch, 10);
        bus(1'b1, REG_MODE_CTRL, 32'h4, v);
        measure();
        chk(n_ale, 5);
        chk(n_fetch, 0);
        bus(1'b1, REG_MODE_CTRL, 32'h1, v);
        cyc(12);
        chk({ale_o, fetch_n_o, p0_float_o, p2_addr_o, cpu_run_o, osc_run_o}, 6'h3D);
        bus(1'b0, REG_STROBE_DIS, 32'h0, v);
        chk(v, 32'h1);
        irq_i <= 1'b1;
        cyc(12);
        chk(cpu_run_o, 1);
        irq_i <= 1'b0;
        bus(1'b1, REG_MODE_CTRL, 32'h1, v);
        seen = 1'b0;
        rst_pin_i <= 1'b1;
        repeat (40) begin
            @(posedge clk_i);
            seen = seen | (ram_block_o === 1'b1);
        end
        chk(seen, 1);
        pin_reset(1);
        bus(1'b1, REG_STROBE_DIS, 32'h1, v);
        bus(1'b1, REG_MODE_CTRL, 32'h2, v);
        cyc(12);
        chk({ale_o, fetch_n_o, p0_float_o, p2_addr_o, osc_run_o}, 5'h04);
        irq_i <= 1'b1;
        cyc(24);
        chk(osc_run_o, 0);
        irq_i <= 1'b0;
        rst_pin_i <= 1'b1;
        cyc(20);
        chk(dev_reset_o, 0);
        cyc(12);
        chk(dev_reset_o, 1);
        pin_reset(1);
        bus(1'b0, REG_STROBE_DIS, 32'h0, v);
        chk({osc_run_o, v}, {1'b1, 32'h0});
        {lb1_i, sel_i} <= 2'b11;
        pin_reset(40);
        sel_i <= 1'b0;
        cyc(24);
        chk(ext_exec_o, 0);
        program_pulse_in_mode_i <= 1'b1;
        preq <= 1'b1;
        cyc(4);
        chk({program_pulse_in_pulse_o, ale_oe_n_o}, 2'b11);
        complete_run();
    end
endmodule : testbench
